// ===== logic/host_ctl_pkg.sv
// shared constants and types for the host control block
package host_ctl_pkg;
  // ****************************************
  // widths and addresses
  // ****************************************
  localparam int          DATA_W            = 32;
  localparam logic [31:0] DEFAULT_SCP_ADDR  = 32'h00FFFFF6;
  localparam logic [31:0] WORD_RESET        = 32'h00000000;
  // direct access opcode lives in the low bits of the first word
  localparam int          OPC_LSB           = 0;
  localparam int          OPC_W             = 4;
  localparam logic [3:0]  OPC_SW_RESET      = 4'h0;
  localparam logic [3:0]  OPC_SELF_TEST     = 4'h1;
  localparam logic [3:0]  OPC_ALT_SCP       = 4'h2;
  localparam logic [3:0]  OPC_DUMP          = 4'h3;
  // ****************************************
  // reset qualification counts
  // ****************************************
  localparam logic [2:0]  RST_SYS_CYCLES    = 3'h5;
  localparam logic [2:0]  RST_TX_CYCLES     = 3'h4;
  localparam logic [2:0]  CNT_ZERO          = 3'h0;
  localparam logic [1:0]  TOG_ZERO          = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INIT,
    ST_RUN
  } unit_state_t;
endpackage : host_ctl_pkg

// ===== logic/tx_clock_counter.sv
// transmit clock edge detector feeding the reset qualifier
`timescale 1ns/1ps
`default_nettype none
module tx_clock_counter (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic serial_tx_clock,
  output logic      tx_rise
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       rise_nxt;

  // two-stage synchroniser then a third stage for edge detection
  always_comb begin
    sync_nxt = {sync_r[1:0], serial_tx_clock};
    rise_nxt = sync_r[1] & ~sync_r[2];
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync_r  <= 3'h0;
      tx_rise <= 1'b0;
    end else begin
      sync_r  <= sync_nxt;
      tx_rise <= rise_nxt;
    end
  end
endmodule : tx_clock_counter
`default_nettype wire

// ===== logic/lan_coproc_host_control.sv
// host facing control of the LAN coprocessor: port access, reset, wakeup, interrupt
`timescale 1ns/1ps
`default_nettype none
module lan_coproc_host_control (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        reset_pin,
  input  wire logic        serial_tx_clock,
  input  wire logic        port_strobe,
  input  wire logic [31:0] data_bus,
  input  wire logic        host_wakeup_strobe,
  input  wire logic        byte_order_select,
  input  wire logic        int_active_low,
  input  wire logic        scb_changed,
  output logic             int_pin,
  output logic             little_endian,
  output logic             device_reset,
  output logic             init_start,
  output logic [31:0]      fetch_addr,
  output logic             cmd_start,
  output logic             dump_start,
  output logic [31:0]      dump_addr,
  output logic             self_test_start,
  output logic [31:0]      self_test_addr
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] rst_s_r, ca_s_r, port_s_r, le_s_r, pol_s_r;
  logic       ca_d_r, port_d_r, tx_rise;
  logic [31:0] bus_s0_r, bus_s1_r; // data bus stages, read only through the second one

  // first stages feed only the second stages
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rst_s_r  <= 2'h0;
      ca_s_r   <= 2'h0;
      port_s_r <= 2'h0;
      le_s_r   <= 2'h0;
      pol_s_r  <= 2'h0;
      bus_s0_r <= host_ctl_pkg::WORD_RESET;
      bus_s1_r <= host_ctl_pkg::WORD_RESET;
      ca_d_r   <= 1'b0;
      port_d_r <= 1'b0;
    end else begin
      rst_s_r  <= {rst_s_r[0], reset_pin};
      ca_s_r   <= {ca_s_r[0], host_wakeup_strobe};
      port_s_r <= {port_s_r[0], port_strobe};
      le_s_r   <= {le_s_r[0], byte_order_select};
      pol_s_r  <= {pol_s_r[0], int_active_low};
      // the host holds the word steady around the strobe, so equal delay keeps it aligned with port_rise
      bus_s0_r <= data_bus;
      bus_s1_r <= bus_s0_r;
      ca_d_r   <= ca_s_r[1];
      port_d_r <= port_s_r[1];
    end
  end

  wire ca_fall   = ca_d_r & ~ca_s_r[1];
  wire port_rise = port_s_r[1] & ~port_d_r;

  tx_clock_counter u_txc (
    .clock           (clock),
    .reset_n         (reset_n),
    .serial_tx_clock (serial_tx_clock),
    .tx_rise         (tx_rise)
  );

  // ****************************************
  // reset qualification
  // ****************************************
  logic [2:0] sys_cnt_r, sys_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
  logic       rst_now;

  // both counters must saturate while the pin stays high; sw reset joins in
  always_comb begin
    sys_cnt_nxt = sys_cnt_r;
    tx_cnt_nxt  = tx_cnt_r;
    if (!rst_s_r[1]) begin
      sys_cnt_nxt = host_ctl_pkg::CNT_ZERO;
      tx_cnt_nxt  = host_ctl_pkg::CNT_ZERO;
    end else begin
      if (sys_cnt_r != host_ctl_pkg::RST_SYS_CYCLES) sys_cnt_nxt = sys_cnt_r + 3'h1;
      if (tx_rise && tx_cnt_r != host_ctl_pkg::RST_TX_CYCLES) tx_cnt_nxt = tx_cnt_r + 3'h1;
    end
  end

  assign rst_now = (sys_cnt_r == host_ctl_pkg::RST_SYS_CYCLES) &&
                   (tx_cnt_r == host_ctl_pkg::RST_TX_CYCLES);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sys_cnt_r <= host_ctl_pkg::CNT_ZERO;
      tx_cnt_r  <= host_ctl_pkg::CNT_ZERO;
    end else begin
      sys_cnt_r <= sys_cnt_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
    end
  end

  // ****************************************
  // port access capture and decode
  // ****************************************
  logic [31:0] word0_r, word0_nxt, word1_r, word1_nxt, scp_r, scp_nxt;
  logic        half_r, half_nxt, done_nxt, sw_rst_r, sw_rst_nxt;
  logic        dump_nxt, st_nxt;
  logic [3:0]  opc;

  // decode happens only on the completing second strobe
  always_comb begin
    word0_nxt  = word0_r;
    word1_nxt  = word1_r;
    scp_nxt    = scp_r;
    half_nxt   = half_r;
    done_nxt   = 1'b0;
    sw_rst_nxt = 1'b0;
    dump_nxt   = 1'b0;
    st_nxt     = 1'b0;
    opc        = word0_r[host_ctl_pkg::OPC_LSB +: host_ctl_pkg::OPC_W];
    if (port_rise) begin
      if (!half_r) word0_nxt = bus_s1_r;
      else word1_nxt = bus_s1_r;
      half_nxt = ~half_r;
      done_nxt = half_r;
    end
    if (done_nxt) begin
      case (opc)
        host_ctl_pkg::OPC_SW_RESET:  sw_rst_nxt = 1'b1;
        host_ctl_pkg::OPC_SELF_TEST: st_nxt = 1'b1;
        host_ctl_pkg::OPC_ALT_SCP:   scp_nxt = bus_s1_r;
        host_ctl_pkg::OPC_DUMP:      dump_nxt = 1'b1;
        default:                     done_nxt = 1'b0;
      endcase
    end
    if (rst_now) begin
      half_nxt = 1'b0;
      scp_nxt  = host_ctl_pkg::DEFAULT_SCP_ADDR;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      word0_r         <= host_ctl_pkg::WORD_RESET;
      word1_r         <= host_ctl_pkg::WORD_RESET;
      scp_r           <= host_ctl_pkg::DEFAULT_SCP_ADDR;
      half_r          <= 1'b0;
      sw_rst_r        <= 1'b0;
      dump_start      <= 1'b0;
      dump_addr       <= host_ctl_pkg::WORD_RESET;
      self_test_start <= 1'b0;
      self_test_addr  <= host_ctl_pkg::WORD_RESET;
    end else begin
      word0_r         <= word0_nxt;
      word1_r         <= word1_nxt;
      scp_r           <= scp_nxt;
      half_r          <= half_nxt;
      sw_rst_r        <= sw_rst_nxt;
      dump_start      <= dump_nxt;
      self_test_start <= st_nxt;
      if (dump_nxt) dump_addr <= bus_s1_r;
      if (st_nxt) self_test_addr <= bus_s1_r;
    end
  end

  // ****************************************
  // unit sequencing and outputs
  // ****************************************
  host_ctl_pkg::unit_state_t st_r, st_nxt_s;
  logic any_rst, int_lvl_r, int_lvl_nxt;
  assign any_rst = rst_now | sw_rst_r;

  // first wakeup after reset initialises, later ones run commands
  always_comb begin
    st_nxt_s = st_r;
    case (st_r)
      host_ctl_pkg::ST_IDLE: if (ca_fall) st_nxt_s = host_ctl_pkg::ST_INIT;
      host_ctl_pkg::ST_INIT: st_nxt_s = host_ctl_pkg::ST_RUN;
      host_ctl_pkg::ST_RUN:  st_nxt_s = host_ctl_pkg::ST_RUN;
      default:               st_nxt_s = host_ctl_pkg::ST_IDLE;
    endcase
    if (any_rst) st_nxt_s = host_ctl_pkg::ST_IDLE;
    // one cycle pulse per change gives a fresh edge; back to back changes merge into one
    int_lvl_nxt = int_lvl_r;
    if (any_rst) int_lvl_nxt = 1'b0;
    else if (scb_changed) int_lvl_nxt = 1'b1;
    else int_lvl_nxt = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r          <= host_ctl_pkg::ST_IDLE;
      int_lvl_r     <= 1'b0;
      int_pin       <= 1'b0;
      little_endian <= 1'b0;
      device_reset  <= 1'b0;
      init_start    <= 1'b0;
      fetch_addr    <= host_ctl_pkg::DEFAULT_SCP_ADDR;
      cmd_start     <= 1'b0;
    end else begin
      st_r          <= st_nxt_s;
      int_lvl_r     <= int_lvl_nxt;
      int_pin       <= int_lvl_nxt ^ pol_s_r[1];
      little_endian <= le_s_r[1];
      device_reset  <= any_rst;
      init_start    <= ca_fall && !any_rst && st_r == host_ctl_pkg::ST_IDLE;
      if (ca_fall && st_r == host_ctl_pkg::ST_IDLE) fetch_addr <= scp_r;
      cmd_start     <= ca_fall && !any_rst && st_r == host_ctl_pkg::ST_RUN;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_reset_needs_counts: assert property (@(posedge clock) disable iff (!reset_n)
    rst_now |-> $past(rst_s_r[1], 5)) else $error("reset before five clocks");
  a_cmd_after_init: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_start |-> st_r == host_ctl_pkg::ST_RUN) else $error("command before init");
  a_init_on_fall: assert property (@(posedge clock) disable iff (!reset_n)
    init_start |-> $past(ca_fall)) else $error("init without wakeup");
  // pin to output is three flops, so compare against the pin itself
  a_byte_order: assert property (@(posedge clock) disable iff (!reset_n)
    ##3 little_endian == $past(byte_order_select, 3)) else $error("byte order wrong");
  a_port_second: assert property (@(posedge clock) disable iff (!reset_n)
    dump_start |-> !half_r) else $error("dump on first word");
  a_capture_word: assert property (@(posedge clock) disable iff (!reset_n)
    (port_rise && !half_r) |=> word0_r == $past(data_bus, 3)) else $error("word not captured");
  a_int_polarity: assert property (@(posedge clock) disable iff (!reset_n)
    ##3 int_pin == (($past(scb_changed) & ~$past(any_rst)) ^ $past(int_active_low, 3))) else $error("int polarity");
  a_reset_aborts: assert property (@(posedge clock) disable iff (!reset_n)
    device_reset |-> st_r == host_ctl_pkg::ST_IDLE) else $error("reset not aborting");
endmodule : lan_coproc_host_control
`default_nettype wire

// ===== tb/host_model.sv
// host processor model: port, wakeup and reset strobes plus the transmit clock
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clock,
  output logic             reset_pin,
  output logic             serial_tx_clock,
  output logic             port_strobe,
  output logic [31:0]      data_bus,
  output logic             host_wakeup_strobe
);
  logic [1:0] tx_div_r;

  // idle levels at time zero
  initial begin
    reset_pin = 1'b0;
    serial_tx_clock = 1'b0;
    port_strobe = 1'b0;
    data_bus = 32'h00000000;
    host_wakeup_strobe = 1'b0;
    tx_div_r = 2'h0;
  end

  // transmit clock runs free, six system clocks per period
  always @(posedge clock) begin
    tx_div_r <= (tx_div_r == 2'h2) ? 2'h0 : tx_div_r + 2'h1;
    if (tx_div_r == 2'h2) serial_tx_clock <= ~serial_tx_clock;
  end

  // one strobe: data settles two clocks early, held well past the fall
  task automatic port_word(input logic [31:0] word);
    @(posedge clock) data_bus <= word;
    repeat (2) @(posedge clock);
    port_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    port_strobe <= 1'b0;
    repeat (4) @(posedge clock);
    data_bus <= ~word; // a released bus must not show the old word
  endtask : port_word

  // a command is always two strobes, opcode word then address word
  task automatic port_cmd(input logic [3:0] opc, input logic [31:0] addr);
    port_word({28'h0000000, opc});
    port_word(addr);
  endtask : port_cmd

  // wakeup held for at least one system clock
  task automatic wakeup(input int hold);
    @(posedge clock) host_wakeup_strobe <= 1'b1;
    repeat (hold) @(posedge clock);
    host_wakeup_strobe <= 1'b0;
  endtask : wakeup

  // reset pin high for the given number of system clocks
  task automatic pin_reset(input int hold);
    @(posedge clock) reset_pin <= 1'b1;
    repeat (hold) @(posedge clock);
    reset_pin <= 1'b0;
  endtask : pin_reset
endmodule : host_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the host control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, reset_n, byte_order_select, int_active_low, scb_changed;
  wire logic reset_pin, serial_tx_clock, port_strobe, host_wakeup_strobe;
  wire logic [31:0] data_bus, fetch_addr, dump_addr, self_test_addr;
  wire logic int_pin, little_endian, device_reset, init_start, cmd_start, dump_start, self_test_start;
  int num_errors = 0, checks_done = 0, cycles = 0;
  int n_init = 0, n_cmd = 0, n_dump = 0, n_test = 0, n_rst = 0, n_int = 0, n_early = 0, d;

  always #10 clock = ~clock;

  host_model u_host (.clock(clock), .reset_pin(reset_pin), .serial_tx_clock(serial_tx_clock),
    .port_strobe(port_strobe), .data_bus(data_bus), .host_wakeup_strobe(host_wakeup_strobe));

  lan_coproc_host_control u_dut (.clock(clock), .reset_n(reset_n), .reset_pin(reset_pin),
    .serial_tx_clock(serial_tx_clock), .port_strobe(port_strobe), .data_bus(data_bus),
    .host_wakeup_strobe(host_wakeup_strobe), .byte_order_select(byte_order_select),
    .int_active_low(int_active_low), .scb_changed(scb_changed), .int_pin(int_pin),
    .little_endian(little_endian), .device_reset(device_reset), .init_start(init_start),
    .fetch_addr(fetch_addr), .cmd_start(cmd_start), .dump_start(dump_start), .dump_addr(dump_addr),
    .self_test_start(self_test_start), .self_test_addr(self_test_addr));

  // pulse counters; early counts a start while the wakeup pin is still high
  always @(posedge clock) begin
    n_init += (init_start === 1'b1);
    n_cmd += (cmd_start === 1'b1);
    n_dump += (dump_start === 1'b1);
    n_test += (self_test_start === 1'b1);
    n_rst += (device_reset === 1'b1);
    n_int += (int_pin !== int_active_low);
    n_early += ((init_start | cmd_start) === 1'b1 && host_wakeup_strobe);
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  // wakeup then compare init and command pulse counts
  task automatic wake_expect(input int inits, input int cmds, input logic [31:0] addr);
    int di = n_init;
    int dc = n_cmd;
    u_host.wakeup(10);
    repeat (8) @(posedge clock);
    check(n_init - di, inits, "init pulses");
    check(n_cmd - dc, cmds, "command pulses");
    check(fetch_addr, addr, "fetch address");
  endtask : wake_expect

  task automatic t_byte_order();
    for (int v = 1; v >= 0; v--) begin
      byte_order_select <= v[0];
      repeat (4) @(posedge clock);
      check(little_endian, v, "byte order");
    end
    $display("byte order done");
  endtask : t_byte_order

  // first wakeup initialises from the default pointer, the next one runs commands
  task automatic t_wakeup();
    check(fetch_addr, host_ctl_pkg::DEFAULT_SCP_ADDR, "reset fetch address");
    wake_expect(1, 0, host_ctl_pkg::DEFAULT_SCP_ADDR);
    wake_expect(0, 1, host_ctl_pkg::DEFAULT_SCP_ADDR);
    $display("wakeup done");
  endtask : t_wakeup

  // a pin reset restores the default pointer, then a port write replaces it
  task automatic t_alt_pointer();
    u_host.pin_reset(40);
    repeat (8) @(posedge clock);
    u_host.port_cmd(host_ctl_pkg::OPC_ALT_SCP, 32'h00123450);
    wake_expect(1, 0, 32'h00123450);
    $display("alternate pointer done");
  endtask : t_alt_pointer

  task automatic t_reset_qual();
    d = n_rst;
    u_host.pin_reset(5);
    repeat (10) @(posedge clock);
    check(n_rst - d, 0, "short reset taken");
    u_host.pin_reset(40);
    repeat (8) @(posedge clock);
    check(n_rst != d, 1, "long reset ignored");
    wake_expect(1, 0, host_ctl_pkg::DEFAULT_SCP_ADDR);
    $display("reset qualification done");
  endtask : t_reset_qual

  // dump over two strobes, self test, unknown code, then software reset
  task automatic t_port_ops();
    d = n_dump;
    u_host.port_word({28'h0000000, host_ctl_pkg::OPC_DUMP});
    repeat (6) @(posedge clock);
    check(n_dump - d, 0, "dump after one strobe");
    u_host.port_word(32'hA5A5A5A4);
    repeat (6) @(posedge clock);
    check(n_dump - d, 1, "dump pulse");
    check(dump_addr, 32'hA5A5A5A4, "dump address");
    d = n_test;
    u_host.port_cmd(host_ctl_pkg::OPC_SELF_TEST, 32'h5A5A5A58);
    u_host.port_cmd(4'hF, 32'hFFFFFFFC);
    repeat (6) @(posedge clock);
    check(n_test - d, 1, "self test pulse");
    check(self_test_addr, 32'h5A5A5A58, "self test address");
    u_host.port_cmd(host_ctl_pkg::OPC_SW_RESET, 32'h00000000);
    repeat (6) @(posedge clock);
    wake_expect(1, 0, 32'h00123450);
    $display("port operations done");
  endtask : t_port_ops

  task automatic t_interrupt();
    for (int p = 0; p < 2; p++) begin
      int_active_low <= p[0];
      repeat (6) @(posedge clock);
      d = n_int;
      scb_changed <= 1'b1;
      @(posedge clock) scb_changed <= 1'b0;
      repeat (6) @(posedge clock);
      check(n_int - d, 1, "interrupt pulse");
      check(int_pin, p, "interrupt idle level");
    end
    $display("interrupt done");
  endtask : t_interrupt

  initial begin
    reset_n = 1'b0;
    byte_order_select = 1'b0;
    int_active_low = 1'b0;
    scb_changed = 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_byte_order();
    t_wakeup();
    t_reset_qual();
    t_alt_pointer();
    t_port_ops();
    t_interrupt();
    check(n_early, 0, "start while wakeup high");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
